// ---- include/sprs_pkg.sv ----
/*
  Package for the serial pin route select block: register addresses, field
  positions, reset values and selector encodings.
  Assumes an 8-bit register port with a 12-bit byte address.
*/
package sprs_pkg;

  // Register addresses.
  localparam logic [11:0] ADDR_PB_READBACK  = 12'h018;
  localparam logic [11:0] ADDR_PB_OUT_TYPE  = 12'hf4c;
  localparam logic [11:0] ADDR_UART_SWAP    = 12'hf57;
  localparam logic [11:0] ADDR_ROUTE_SELECT = 12'hfcb;

  // Reset values.
  localparam logic [7:0] RST_PB_OUT_TYPE  = 8'h00;
  localparam logic [2:0] RST_UART_SWAP    = 3'h0;
  localparam logic [1:0] RST_TIMER_SEL    = 2'h0;
  localparam logic       RST_GROUP_SEL    = 1'b0;
  localparam logic [1:0] RST_CH1_SEL      = 2'h0;
  localparam logic [1:0] RST_CH0_SEL      = 2'h0;

  // Field positions in the route select register.
  localparam int ROUTE_CH0_LSB   = 0;
  localparam int ROUTE_CH1_LSB   = 2;
  localparam int ROUTE_GROUP_BIT = 4;
  localparam int ROUTE_TIMER_LSB = 6;

  // Field positions in the swap register.
  localparam int SWAP_UART0_BIT = 0;
  localparam int SWAP_UART1_BIT = 1;
  localparam int SWAP_UART2_BIT = 2;

  // Channel 0 function pairs.
  typedef enum logic [1:0] {
    SPRS_CH0_UART_BUS  = 2'b00,
    SPRS_CH0_UART_SIO  = 2'b01,
    SPRS_CH0_SIO_BUS   = 2'b10,
    SPRS_CH0_RESERVED  = 2'b11
  } sprs_ch0_t;

  // Timer capture input sources.
  typedef enum logic [1:0] {
    SPRS_TMR_PIN   = 2'b00,
    SPRS_TMR_UART0 = 2'b01,
    SPRS_TMR_UART1 = 2'b10,
    SPRS_TMR_UART2 = 2'b11
  } sprs_tmr_t;

  localparam logic [1:0] CH1_SIO      = 2'b10;
  localparam logic [1:0] CH1_RESERVED = 2'b11;

endpackage

// ---- logic/sprs_uart_pair.sv ----
/*
  Pin pair steering for one UART: places transmit and receive on a pin pair
  in default or swapped order.
  Assumes pin 0 carries transmit and pin 1 receive in the default order.
*/
`timescale 1ns/1ns
module sprs_uart_pair (
  // Control.
  input  wire logic       i_swap,
  // Pin pair levels.
  input  wire logic [1:0] i_pin,
  // Results.
  output logic [1:0]      o_tx_sel,
  output logic            o_rxd
);

  always_comb begin
    if (i_swap) begin
      o_tx_sel = 2'b10;
      o_rxd    = i_pin[0];
    end else begin
      o_tx_sel = 2'b01;
      o_rxd    = i_pin[1];
    end
  end

endmodule

// ---- logic/sprs_route.sv ----
/*
  Serial pin route select: registers and routing of channel 0, channel 1 and
  UART2 serial functions to port pins, shared interrupt latches, timer capture
  input selection and port B output type with pin read-back.
  Assumes synchronous pin inputs, the port direction and data registers held
  elsewhere, and software keeping the selection stable while units run.
*/
// Local design decision: the address-and-strobe port.
// Summary of operation
// - Read-back gives pin level unless bit is push-pull output, then zero.
// - Any two of three channel 0 functions run together; serial+bus needs the group bit clear.
// - Channel 1 connects either UART1 or clocked serial, never both.
// - Timer selector: pin, UART0, UART1 or UART2 receive pin.
// - Channel 0 selector: 00 UART+bus, 01 UART+serial, 10 serial+bus.
// - Shared latches carry whichever function the selection routes.
// - Nonzero timer selector uses the UART receive pin after swapping.
// - Each swap bit exchanges its UART's receive and transmit pins.
// - Swap register bits seven to three read as zero.
`timescale 1ns/1ns
module sprs_route (
  // Clock and reset.
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  // Register port.
  input  wire logic [11:0] i_addr,
  input  wire logic [7:0]  i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic [7:0]       o_rdata,
  // Port B.
  input  wire logic [5:0]  i_pb_dir,
  input  wire logic [5:0]  i_pb_data,
  input  wire logic [5:0]  i_pb_pin,
  output logic [5:0]       o_pb_out,
  output logic [5:0]       o_pb_oe_n,
  // Port 2 pins and their plain port drive.
  input  wire logic [5:0]  i_p2_pin,
  input  wire logic [5:0]  i_p2_gpio_out,
  input  wire logic [5:0]  i_p2_gpio_oe_n,
  output logic [5:0]       o_p2_out,
  output logic [5:0]       o_p2_oe_n,
  // Port 9 pins and their plain port drive.
  input  wire logic [4:0]  i_p9_pin,
  input  wire logic [4:0]  i_p9_gpio_out,
  input  wire logic [4:0]  i_p9_gpio_oe_n,
  output logic [4:0]       o_p9_out,
  output logic [4:0]       o_p9_oe_n,
  // Timer capture.
  input  wire logic        i_timer_pin,
  output logic             o_timer_capture,
  // UART engines.
  input  wire logic        i_uart0_txd,
  input  wire logic        i_uart1_txd,
  input  wire logic        i_uart2_txd,
  output logic             o_uart0_rxd,
  output logic             o_uart1_rxd,
  output logic             o_uart2_rxd,
  // Clocked serial engines.
  input  wire logic        i_clocked_serial_ch0_so,
  input  wire logic        i_clocked_serial_ch0_sclk,
  input  wire logic        i_clocked_serial_ch1_so,
  input  wire logic        i_clocked_serial_ch1_sclk,
  output logic             o_clocked_serial_ch0_si,
  output logic             o_clocked_serial_ch1_si,
  // Two-wire bus engine.
  input  wire logic        i_i2c_sda_out,
  input  wire logic        i_i2c_scl_out,
  output logic             o_i2c_sda_in,
  output logic             o_i2c_scl_in,
  // Engine interrupt sources.
  input  wire logic        i_uart0_tx_irq,
  input  wire logic        i_uart0_rx_irq,
  input  wire logic        i_clocked_serial_ch0_irq,
  input  wire logic        i_i2c_irq,
  input  wire logic        i_uart1_tx_irq,
  input  wire logic        i_uart1_rx_irq,
  input  wire logic        i_clocked_serial_ch1_irq,
  // Shared interrupt latch requests.
  output logic             o_latch_tx0,
  output logic             o_latch_rx0_clocked_serial_ch0,
  output logic             o_latch_bus0_clocked_serial_ch0,
  output logic             o_latch_tx1,
  output logic             o_latch_rx1_clocked_serial_ch1,
  // Function enables.
  output logic             o_uart0_en,
  output logic             o_clocked_serial_ch0_en,
  output logic             o_i2c_en,
  output logic             o_uart1_en,
  output logic             o_clocked_serial_ch1_en
);

  logic [7:0] otype_reg;
  logic [2:0] swap_reg;
  logic [1:0] timer_sel_reg;
  logic       group_reg;
  logic [1:0] ch1_reg;
  sprs_pkg::sprs_ch0_t ch0_reg;

  logic       ch0_ok, uart0_on, clocked_serial_ch0_on, i2c_on, uart1_on, clocked_serial_ch1_on;
  logic [1:0] u0_pins, u0_tx_sel, u1_tx_sel, u2_tx_sel;
  logic       u0_rxd, u1_rxd, u2_rxd;
  logic [7:0] rdata_next;
  logic [5:0] pb_out_next, pb_oe_n_next, p2_out_next, p2_oe_n_next;
  logic [4:0] p9_out_next, p9_oe_n_next;
  logic       timer_next;

  // Returns {level, enable_n}; open drain drives only a low level.
  function automatic logic [1:0] drive_pin(input logic en, input logic od, input logic val);
    if (!en) begin
      drive_pin = 2'b01;
    end else if (od) begin
      drive_pin = {1'b0, val};
    end else begin
      drive_pin = {val, 1'b0};
    end
  endfunction

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      otype_reg <= sprs_pkg::RST_PB_OUT_TYPE;
    end else if (i_wr && i_addr == sprs_pkg::ADDR_PB_OUT_TYPE) begin
      otype_reg <= i_wdata;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      swap_reg <= sprs_pkg::RST_UART_SWAP;
    end else if (i_wr && i_addr == sprs_pkg::ADDR_UART_SWAP) begin
      swap_reg <= i_wdata[2:0];
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      timer_sel_reg <= sprs_pkg::RST_TIMER_SEL;
      group_reg     <= sprs_pkg::RST_GROUP_SEL;
      ch1_reg       <= sprs_pkg::RST_CH1_SEL;
      ch0_reg       <= sprs_pkg::sprs_ch0_t'(sprs_pkg::RST_CH0_SEL);
    end else if (i_wr && i_addr == sprs_pkg::ADDR_ROUTE_SELECT) begin
      timer_sel_reg <= i_wdata[sprs_pkg::ROUTE_TIMER_LSB +: 2];
      group_reg     <= i_wdata[sprs_pkg::ROUTE_GROUP_BIT];
      ch1_reg       <= i_wdata[sprs_pkg::ROUTE_CH1_LSB +: 2];
      ch0_reg       <= sprs_pkg::sprs_ch0_t'(i_wdata[sprs_pkg::ROUTE_CH0_LSB +: 2]);
    end
  end

  // Reserved codes connect nothing, so a bad write cannot drive two units.
  assign ch0_ok   = ch0_reg != sprs_pkg::SPRS_CH0_RESERVED
                    && !(ch0_reg == sprs_pkg::SPRS_CH0_SIO_BUS && group_reg);
  assign uart0_on = ch0_ok && ch0_reg != sprs_pkg::SPRS_CH0_SIO_BUS;
  assign i2c_on   = ch0_ok && ch0_reg != sprs_pkg::SPRS_CH0_UART_SIO;
  assign clocked_serial_ch0_on  = ch0_ok && ch0_reg != sprs_pkg::SPRS_CH0_UART_BUS;
  assign uart1_on = !ch1_reg[1];
  assign clocked_serial_ch1_on  = ch1_reg == sprs_pkg::CH1_SIO;
  assign u0_pins  = group_reg ? i_pb_pin[5:4] : i_p2_pin[1:0];

  sprs_uart_pair u_pair0 (
    .i_swap   (swap_reg[sprs_pkg::SWAP_UART0_BIT]),
    .i_pin    (u0_pins),
    .o_tx_sel (u0_tx_sel),
    .o_rxd    (u0_rxd)
  );
  sprs_uart_pair u_pair1 (
    .i_swap   (swap_reg[sprs_pkg::SWAP_UART1_BIT]),
    .i_pin    (i_p9_pin[1:0]),
    .o_tx_sel (u1_tx_sel),
    .o_rxd    (u1_rxd)
  );
  sprs_uart_pair u_pair2 (
    .i_swap   (swap_reg[sprs_pkg::SWAP_UART2_BIT]),
    .i_pin    (i_p9_pin[4:3]),
    .o_tx_sel (u2_tx_sel),
    .o_rxd    (u2_rxd)
  );

  // Pin drive for all three ports.
  always_comb begin
    p2_out_next  = i_p2_gpio_out;
    p2_oe_n_next = i_p2_gpio_oe_n;
    p9_out_next  = i_p9_gpio_out;
    p9_oe_n_next = i_p9_gpio_oe_n;
    for (int i = 0; i < 6; i++) begin
      {pb_out_next[i], pb_oe_n_next[i]} = drive_pin(i_pb_dir[i], otype_reg[i], i_pb_data[i]);
    end
    for (int k = 0; k < 2; k++) begin
      if (uart0_on && group_reg) begin
        {pb_out_next[4+k], pb_oe_n_next[4+k]} =
          drive_pin(u0_tx_sel[k], otype_reg[4+k], i_uart0_txd);
      end else if (uart0_on) begin
        {p2_out_next[k], p2_oe_n_next[k]} = drive_pin(u0_tx_sel[k], 1'b0, i_uart0_txd);
      end
      if (uart1_on) begin
        {p9_out_next[k], p9_oe_n_next[k]} = drive_pin(u1_tx_sel[k], 1'b0, i_uart1_txd);
      end
      {p9_out_next[3+k], p9_oe_n_next[3+k]} = drive_pin(u2_tx_sel[k], 1'b0, i_uart2_txd);
    end
    if (clocked_serial_ch0_on && ch0_reg == sprs_pkg::SPRS_CH0_SIO_BUS) begin
      {p2_out_next[0], p2_oe_n_next[0]} = drive_pin(1'b1, 1'b0, i_clocked_serial_ch0_so);
      {p2_out_next[1], p2_oe_n_next[1]} = 2'b01;
      {p2_out_next[2], p2_oe_n_next[2]} = drive_pin(1'b1, 1'b0, i_clocked_serial_ch0_sclk);
    end
    if (clocked_serial_ch0_on && ch0_reg == sprs_pkg::SPRS_CH0_UART_SIO) begin
      {p2_out_next[3], p2_oe_n_next[3]} = drive_pin(1'b1, 1'b0, i_clocked_serial_ch0_so);
      {p2_out_next[4], p2_oe_n_next[4]} = 2'b01;
      {p2_out_next[5], p2_oe_n_next[5]} = drive_pin(1'b1, 1'b0, i_clocked_serial_ch0_sclk);
    end
    if (i2c_on) begin
      {p2_out_next[3], p2_oe_n_next[3]} = drive_pin(1'b1, 1'b1, i_i2c_sda_out);
      {p2_out_next[4], p2_oe_n_next[4]} = drive_pin(1'b1, 1'b1, i_i2c_scl_out);
    end
    if (clocked_serial_ch1_on) begin
      {p9_out_next[0], p9_oe_n_next[0]} = drive_pin(1'b1, 1'b0, i_clocked_serial_ch1_so);
      {p9_out_next[1], p9_oe_n_next[1]} = 2'b01;
      {p9_out_next[2], p9_oe_n_next[2]} = drive_pin(1'b1, 1'b0, i_clocked_serial_ch1_sclk);
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_pb_out  <= 6'h00;
      o_pb_oe_n <= 6'h3f;
      o_p2_out  <= 6'h00;
      o_p2_oe_n <= 6'h3f;
      o_p9_out  <= 5'h00;
      o_p9_oe_n <= 5'h1f;
    end else begin
      o_pb_out  <= pb_out_next;
      o_pb_oe_n <= pb_oe_n_next;
      o_p2_out  <= p2_out_next;
      o_p2_oe_n <= p2_oe_n_next;
      o_p9_out  <= p9_out_next;
      o_p9_oe_n <= p9_oe_n_next;
    end
  end

  // The receive pin follows the swap bit, so the timer sees the same pin.
  always_comb begin
    unique case (sprs_pkg::sprs_tmr_t'(timer_sel_reg))
      sprs_pkg::SPRS_TMR_PIN:   timer_next = i_timer_pin;
      sprs_pkg::SPRS_TMR_UART0: timer_next = u0_rxd;
      sprs_pkg::SPRS_TMR_UART1: timer_next = u1_rxd;
      sprs_pkg::SPRS_TMR_UART2: timer_next = u2_rxd;
    endcase
  end

  // Unconnected engine inputs idle high so a receiver sees no start bit.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_timer_capture <= 1'b0;
      o_uart0_rxd     <= 1'b1;
      o_uart1_rxd     <= 1'b1;
      o_uart2_rxd     <= 1'b1;
      o_clocked_serial_ch0_si       <= 1'b1;
      o_clocked_serial_ch1_si       <= 1'b1;
      o_i2c_sda_in    <= 1'b1;
      o_i2c_scl_in    <= 1'b1;
    end else begin
      o_timer_capture <= timer_next;
      o_uart0_rxd     <= uart0_on ? u0_rxd : 1'b1;
      o_uart1_rxd     <= uart1_on ? u1_rxd : 1'b1;
      o_uart2_rxd     <= u2_rxd;
      o_clocked_serial_ch0_si       <= !clocked_serial_ch0_on ? 1'b1 :
                         (ch0_reg == sprs_pkg::SPRS_CH0_UART_SIO ? i_p2_pin[4] : i_p2_pin[1]);
      o_clocked_serial_ch1_si       <= clocked_serial_ch1_on ? i_p9_pin[1] : 1'b1;
      o_i2c_sda_in    <= i2c_on ? i_p2_pin[3] : 1'b1;
      o_i2c_scl_in    <= i2c_on ? i_p2_pin[4] : 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_latch_tx0       <= 1'b0;
      o_latch_rx0_clocked_serial_ch0  <= 1'b0;
      o_latch_bus0_clocked_serial_ch0 <= 1'b0;
      o_latch_tx1       <= 1'b0;
      o_latch_rx1_clocked_serial_ch1  <= 1'b0;
      o_uart0_en        <= 1'b0;
      o_clocked_serial_ch0_en         <= 1'b0;
      o_i2c_en          <= 1'b0;
      o_uart1_en        <= 1'b0;
      o_clocked_serial_ch1_en         <= 1'b0;
    end else begin
      o_latch_tx0       <= uart0_on && i_uart0_tx_irq;
      o_latch_rx0_clocked_serial_ch0  <= uart0_on ? i_uart0_rx_irq : (clocked_serial_ch0_on && i_clocked_serial_ch0_irq);
      o_latch_bus0_clocked_serial_ch0 <= i2c_on ? i_i2c_irq : (clocked_serial_ch0_on && i_clocked_serial_ch0_irq);
      o_latch_tx1       <= uart1_on && i_uart1_tx_irq;
      o_latch_rx1_clocked_serial_ch1  <= uart1_on ? i_uart1_rx_irq : (clocked_serial_ch1_on && i_clocked_serial_ch1_irq);
      o_uart0_en        <= uart0_on;
      o_clocked_serial_ch0_en         <= clocked_serial_ch0_on;
      o_i2c_en          <= i2c_on;
      o_uart1_en        <= uart1_on;
      o_clocked_serial_ch1_en         <= clocked_serial_ch1_on;
    end
  end

  always_comb begin
    unique case (i_addr)
      sprs_pkg::ADDR_PB_READBACK:  rdata_next = {2'h0, i_pb_pin & (~i_pb_dir | otype_reg[5:0])};
      sprs_pkg::ADDR_PB_OUT_TYPE:  rdata_next = otype_reg;
      sprs_pkg::ADDR_UART_SWAP:    rdata_next = {5'h00, swap_reg};
      sprs_pkg::ADDR_ROUTE_SELECT: rdata_next = {timer_sel_reg, 1'b0, group_reg, ch1_reg, ch0_reg};
      default:                     rdata_next = 8'h00;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rdata <= 8'h00;
    end else begin
      o_rdata <= i_rd ? rdata_next : 8'h00;
    end
  end

  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  sequence s_sio_routed;
    ch0_reg == sprs_pkg::SPRS_CH0_SIO_BUS && !group_reg;
  endsequence
  sequence s_sio_event;
    s_sio_routed ##0 i_clocked_serial_ch0_irq;
  endsequence

  a_readback_push_pull: assert property ((i_rd && i_addr == sprs_pkg::ADDR_PB_READBACK
    && i_pb_dir[0] && !otype_reg[0]) |=> o_rdata[0] == 1'b0) else $error("push-pull bit read nonzero");
  a_readback_live: assert property ((i_rd && i_addr == sprs_pkg::ADDR_PB_READBACK && !i_pb_dir[2])
    |=> o_rdata[2] == $past(i_pb_pin[2])) else $error("input bit not read live");
  a_swap_upper_zero: assert property ((i_rd && i_addr == sprs_pkg::ADDR_UART_SWAP)
    |=> o_rdata[7:3] == 5'h00) else $error("swap upper bits nonzero");
  a_open_drain_pin: assert property ((i_pb_dir[0] && otype_reg[0]) |=> !o_pb_out[0]
    && o_pb_oe_n[0] == $past(i_pb_data[0])) else $error("open drain drove high");
  // The edge that releases reset is skipped, since the capture flop still holds its reset value.
  a_timer_dedicated: assert property ((i_rst_n && timer_sel_reg == 2'b00) |=> o_timer_capture
    == $past(i_timer_pin)) else $error("timer pin not routed");
  a_timer_uart1_swap: assert property ((timer_sel_reg == 2'b10 && !swap_reg[1]) |=>
    o_timer_capture == $past(i_p9_pin[1])) else $error("timer not on uart1 receive");
  a_ch1_exclusive: assert property (!(o_uart1_en && o_clocked_serial_ch1_en)) else $error("channel 1 doubled");
  a_ch0_two_of_three: assert property (!(o_uart0_en && o_clocked_serial_ch0_en && o_i2c_en))
    else $error("three channel 0 functions");
  a_ch0_uart_sio: assert property ((ch0_reg == sprs_pkg::SPRS_CH0_UART_SIO) |=>
    o_uart0_en && o_clocked_serial_ch0_en && !o_i2c_en) else $error("channel 0 pair wrong");
  a_ch1_reserved: assert property ((ch1_reg == sprs_pkg::CH1_RESERVED) |=>
    !o_uart1_en && !o_clocked_serial_ch1_en) else $error("reserved channel 1 connected");
  a_uart0_group_pb: assert property ((uart0_on && group_reg && !swap_reg[0] && !otype_reg[4])
    |=> !o_pb_oe_n[4] && o_pb_out[4] == $past(i_uart0_txd)) else $error("uart0 not on port B");
  a_shared_latch: assert property (s_sio_event |=> o_latch_rx0_clocked_serial_ch0 && !o_latch_tx0)
    else $error("shared latch not from serial unit");

endmodule

// ---- testbench/tb.sv ----
/*
  Self-checking bench for the serial pin route select block: registers,
  routing of every selector code, port B drive and read-back.
  Assumes the block answers a read in the cycle after the strobe.
*/
`timescale 1ns/1ns
module tb;
  logic        i_clk;
  logic        i_rst_n;
  logic        i_wr;
  logic        i_rd;
  logic [11:0] i_addr;
  logic [7:0]  i_wdata;
  logic [7:0]  o_rdata;
  logic [7:0]  rd_v;
  logic [5:0]  i_pb_dir, i_pb_data, i_pb_pin, o_pb_out, o_pb_oe_n;
  logic [5:0]  i_p2_pin, i_p2_gpio_out, i_p2_gpio_oe_n, o_p2_out, o_p2_oe_n;
  logic [4:0]  i_p9_pin, i_p9_gpio_out, i_p9_gpio_oe_n, o_p9_out, o_p9_oe_n;
  logic [6:0]  irq;
  logic [8:0]  eng;
  logic        tpin;
  logic        o_timer_capture;
  logic [2:0]  rxd;
  logic [1:0]  si;
  logic [1:0]  bus_in;
  logic [4:0]  lat;
  logic [4:0]  en;
  int          fails;
  int          checks;

  sprs_route uut (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_pb_dir(i_pb_dir), .i_pb_data(i_pb_data), .i_pb_pin(i_pb_pin),
    .o_pb_out(o_pb_out), .o_pb_oe_n(o_pb_oe_n),
    .i_p2_pin(i_p2_pin), .i_p2_gpio_out(i_p2_gpio_out), .i_p2_gpio_oe_n(i_p2_gpio_oe_n),
    .o_p2_out(o_p2_out), .o_p2_oe_n(o_p2_oe_n),
    .i_p9_pin(i_p9_pin), .i_p9_gpio_out(i_p9_gpio_out), .i_p9_gpio_oe_n(i_p9_gpio_oe_n),
    .o_p9_out(o_p9_out), .o_p9_oe_n(o_p9_oe_n),
    .i_timer_pin(tpin), .o_timer_capture(o_timer_capture),
    .i_uart0_txd(eng[0]), .i_uart1_txd(eng[1]), .i_uart2_txd(eng[2]),
    .o_uart0_rxd(rxd[0]), .o_uart1_rxd(rxd[1]), .o_uart2_rxd(rxd[2]),
    .i_clocked_serial_ch0_so(eng[3]), .i_clocked_serial_ch0_sclk(eng[4]), .i_clocked_serial_ch1_so(eng[5]), .i_clocked_serial_ch1_sclk(eng[6]),
    .o_clocked_serial_ch0_si(si[0]), .o_clocked_serial_ch1_si(si[1]),
    .i_i2c_sda_out(eng[7]), .i_i2c_scl_out(eng[8]),
    .o_i2c_sda_in(bus_in[0]), .o_i2c_scl_in(bus_in[1]),
    .i_uart0_tx_irq(irq[0]), .i_uart0_rx_irq(irq[1]), .i_clocked_serial_ch0_irq(irq[2]),
    .i_i2c_irq(irq[3]), .i_uart1_tx_irq(irq[4]), .i_uart1_rx_irq(irq[5]),
    .i_clocked_serial_ch1_irq(irq[6]),
    .o_latch_tx0(lat[0]), .o_latch_rx0_clocked_serial_ch0(lat[1]), .o_latch_bus0_clocked_serial_ch0(lat[2]),
    .o_latch_tx1(lat[3]), .o_latch_rx1_clocked_serial_ch1(lat[4]),
    .o_uart0_en(en[4]), .o_clocked_serial_ch0_en(en[3]), .o_i2c_en(en[2]),
    .o_uart1_en(en[1]), .o_clocked_serial_ch1_en(en[0])
  );

  always #25 i_clk = ~i_clk;

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string m);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, m, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    rd_v = o_rdata;
  endtask

  // Every pin and engine input moves at once, so no input is left tied.
  task automatic shake();
    @(posedge i_clk);
    {i_pb_dir, i_pb_data, i_pb_pin} <= 18'($urandom);
    {i_p2_pin, i_p2_gpio_out, i_p2_gpio_oe_n} <= 18'($urandom);
    {i_p9_pin, i_p9_gpio_out, i_p9_gpio_oe_n} <= 15'($urandom);
    {irq, eng, tpin} <= 17'($urandom);
    repeat (3) @(posedge i_clk);
    #1;
  endtask

  // Enables in port order: uart0, clocked_serial_ch0, bus, uart1, clocked_serial_ch1.
  function automatic logic [4:0] f_en(input logic [7:0] r);
    logic u0, s0, b0;
    u0 = r[1:0] < 2'd2;
    s0 = (r[1:0] == 2'd1) || (r[1:0] == 2'd2 && !r[4]);
    b0 = (r[1:0] == 2'd0) || (r[1:0] == 2'd2 && !r[4]);
    return {u0, s0, b0, r[3:2] < 2'd2, r[3:2] == 2'd2};
  endfunction

  // Receive sits on the upper pin of a pair unless swapped.
  function automatic logic f_rx(input logic sw, input logic [1:0] pair);
    return sw ? pair[0] : pair[1];
  endfunction

  task automatic check_pins(input logic [7:0] r, input logic [2:0] sw, input logic [7:0] ty);
    logic [4:0] e;
    logic [3:0] src;
    logic       rx0, rx1, ov, dv, dd;
    logic [1:0] pd, qd;
    int         sb;
    e = f_en(r);
    rx0 = f_rx(sw[0], r[4] ? i_pb_pin[5:4] : i_p2_pin[1:0]);
    rx1 = f_rx(sw[1], i_p9_pin[1:0]);
    src = {f_rx(sw[2], i_p9_pin[4:3]), rx1, rx0, tpin};
    chk(en, e, "enables");
    chk(o_timer_capture, src[r[7:6]], "timer input");
    chk(rxd, {src[3], e[1] ? rx1 : 1'b1, e[4] ? rx0 : 1'b1}, "uart rxd");
    if (e[4] && !r[4]) chk(o_p2_out[sw[0]], eng[0], "uart0 txd");
    if (e[1]) chk(o_p9_out[sw[1]], eng[1], "uart1 txd");
    chk(o_p9_out[sw[2] ? 4 : 3], eng[2], "uart2 txd");
    chk(si, {e[0] ? i_p9_pin[1] : 1'b1,
             e[3] ? (r[1:0] == 2'd1 ? i_p2_pin[4] : i_p2_pin[1]) : 1'b1}, "serial in");
    chk(bus_in, e[2] ? {i_p2_pin[4], i_p2_pin[3]} : 2'b11, "bus in");
    if (|e[4:2]) chk(lat[2:1], {e[2] ? irq[3] : irq[2], e[4] ? irq[1] : irq[2]}, "latch0");
    if (e[4]) chk(lat[0], irq[0], "latch tx0");
    if (|e[1:0]) chk(lat[4], e[1] ? irq[5] : irq[6], "latch1");
    if (e[1]) chk(lat[3], irq[4], "latch tx1");
    for (int i = 0; i < 6; i++) begin
      ov = e[4] && r[4] && i > 3;
      dv = ov ? (i == (sw[0] ? 5 : 4)) : i_pb_dir[i];
      dd = ov ? eng[0] : i_pb_data[i];
      if (!dv) chk(o_pb_oe_n[i], 1'b1, "pb release");
      else chk({o_pb_out[i], o_pb_oe_n[i]}, ty[i] ? {1'b0, dd} : {dd, 1'b0}, "pb drive");
    end
    // Ports 2 and 9 keep their plain drive wherever no routed function owns the pin.
    sb = r[1:0] == 2'd1 ? 3 : 0;
    for (int j = 0; j < 6; j++) begin
      pd = {i_p2_gpio_out[j], i_p2_gpio_oe_n[j]};
      if (e[4] && !r[4] && j < 2) pd = (j == sw[0]) ? {eng[0], 1'b0} : 2'b01;
      if (e[3] && j >= sb && j < sb + 3) begin
        pd = (j == sb + 1) ? 2'b01 : {eng[j == sb ? 3 : 4], 1'b0};
      end
      if (e[2] && (j == 3 || j == 4)) pd = {1'b0, eng[j + 4]};
      chk({o_p2_out[j], o_p2_oe_n[j]}, pd, "port 2 drive");
      if (j < 5) begin
        qd = {i_p9_gpio_out[j], i_p9_gpio_oe_n[j]};
        if (e[1] && j < 2) qd = (j == sw[1]) ? {eng[1], 1'b0} : 2'b01;
        if (e[0] && j < 3) qd = (j == 1) ? 2'b01 : {eng[j == 0 ? 5 : 6], 1'b0};
        if (j > 2) qd = (j == (sw[2] ? 4 : 3)) ? {eng[2], 1'b0} : 2'b01;
        chk({o_p9_out[j], o_p9_oe_n[j]}, qd, "port 9 drive");
      end
    end
    rd(sprs_pkg::ADDR_PB_READBACK);
    chk(rd_v, {2'b00, i_pb_pin & (~i_pb_dir | ty[5:0])}, "readback");
  endtask

  task automatic reset_test(input string name);
    i_rst_n <= 1'b0;
    repeat (5) @(posedge i_clk);
    i_rst_n <= 1'b1;
    rd(sprs_pkg::ADDR_ROUTE_SELECT);
    chk(rd_v, 8'h00, "route reset");
    rd(sprs_pkg::ADDR_UART_SWAP);
    chk(rd_v, 8'h00, "swap reset");
    rd(sprs_pkg::ADDR_PB_OUT_TYPE);
    chk(rd_v, 8'h00, "type reset");
    shake();
    check_pins(8'h00, 3'h0, 8'h00);
    $display("test %s done", name);
  endtask

  initial begin
    logic [7:0]  r, sw, ty;
    logic [11:0] ua;
    i_clk = 1'b0;
    i_rst_n = 1'b0;
    {i_wr, i_rd, i_addr, i_wdata} = '0;
    {i_pb_dir, i_pb_data, i_pb_pin, i_p2_pin, i_p2_gpio_out, i_p2_gpio_oe_n} = '0;
    {i_p9_pin, i_p9_gpio_out, i_p9_gpio_oe_n, irq, eng, tpin} = '0;
    fails = 0;
    checks = 0;
    void'($urandom(25));
    reset_test("reset values");
    // The first 128 passes walk every selector code, the rest are random.
    for (int n = 0; n < 170; n++) begin
      r = n < 128 ? {n[6:5], 1'b0, n[4], n[3:2], n[1:0]} : 8'($urandom);
      // Only the sweep reaches the reserved channel 0 code, to show that it connects nothing.
      if (n >= 128 && r[1:0] == 2'h3) r[1:0] = 2'h1;
      sw = 8'($urandom);
      ty = 8'($urandom) & 8'h3f;
      ua = 12'($urandom);
      if (ua inside {12'h018, 12'hf4c, 12'hf57, 12'hfcb}) ua = 12'h019;
      wr(sprs_pkg::ADDR_ROUTE_SELECT, r);
      wr(sprs_pkg::ADDR_UART_SWAP, sw);
      wr(sprs_pkg::ADDR_PB_OUT_TYPE, ty);
      wr(ua, 8'hff);
      shake();
      check_pins(r, sw[2:0], ty);
      rd(sprs_pkg::ADDR_ROUTE_SELECT);
      chk(rd_v, r & 8'hdf, "route read");
      rd(sprs_pkg::ADDR_UART_SWAP);
      chk(rd_v, {5'h00, sw[2:0]}, "swap read");
      rd(sprs_pkg::ADDR_PB_OUT_TYPE);
      chk(rd_v, ty, "type read");
      rd(ua);
      chk(rd_v, 8'h00, "unmapped read");
    end
    $display("test routing sweep done");
    reset_test("second reset");
    complete_run();
  end

  // The sweep needs about 3800 cycles; this limit allows far more.
  initial begin
    #2000000;
    fails++;
    complete_run();
  end
endmodule
